/* File: logic/fpar_pkg.sv */
// Purpose: Constants and types for the fault protection and auto-restart sequencer.
// Assumes: Clock at 20 MHz; comparator inputs are asynchronous levels.
// Notes: Thresholds themselves live in the analog comparators.
package fpar_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OVLD_TIME_MS = 56;
  localparam int unsigned OVOLT_DEB_US = 150;
  // The overload window is a least time, so the timer compare is strict.
  localparam int unsigned OVLD_CYCLES = (OVLD_TIME_MS * (CLK_HZ / 1000));
  localparam int unsigned OVOLT_CYCLES = (OVOLT_DEB_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned OVLD_CW = 21;
  localparam int unsigned OVOLT_CW = 12;
  localparam logic [OVLD_CW-1:0] OVLD_LIMIT = OVLD_CW'(OVLD_CYCLES);
  localparam logic [OVOLT_CW-1:0] OVOLT_LIMIT = OVOLT_CW'(OVOLT_CYCLES);

  typedef enum logic [2:0] {
    FPAR_ST_CHARGE = 3'b000,
    FPAR_ST_RUN = 3'b001,
    FPAR_ST_FAULT_FALL = 3'b010,
    FPAR_ST_FAULT_SLOW = 3'b011,
    FPAR_ST_LOCKOUT_STOP = 3'b100
  } fpar_state_t;
endpackage

/* File: logic/fpar_sync.sv */
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: Input is a comparator output from outside the clock domain.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module fpar_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level
  input wire logic d_async,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d_async;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* File: logic/fpar_top.sv */
// Purpose: Overload, over-voltage and over-temperature protection with two-level lockout.
// Assumes: Comparator flags arrive asynchronously; switch driver obeys switch_en.
// Notes: Reset brings the block up in the charge state with switching off.
// What this block does
// - Feedback above 4.6 V for over 56 ms triggers overload protection.
// - Supply reaching 28 V triggers over-voltage protection.
// - Over-voltage must persist about 150 us before protection asserts.
// - Die above about 140 C triggers over-temperature protection, switch held off.
// - Over-temperature releases only after die cools 25 C below trip.
// - Any protection trigger starts the two-level lockout sequence.
// - Without protection, supply at 6 V stops switching and starts recharge.
// - Any protection trigger stops switching at once.
// - In a fault, supply at 9 V enters very-low-current mode.
// - In a fault, supply at 6 V clears overload and over-voltage protection and starts recharge.
// - After recharge, switching resumes when supply reaches 12 V.
// - Every protection auto-restarts; switch stays off until lockout ends and, for over-temperature, the die cools to release.
`timescale 1ns/1ps
`default_nettype none
module fpar_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous comparator flags
  input wire logic feedback_level_high,
  input wire logic vdd_above_28v,
  input wire logic vdd_above_12v,
  input wire logic vdd_above_9v,
  input wire logic vdd_above_6v,
  input wire logic temp_above_trip,
  input wire logic temp_above_release,
  // Controls to switch driver and supply path
  output logic switch_en,
  output logic low_current_mode,
  output logic high_voltage_startup_en,
  // Status
  output logic overload_protect,
  output logic supply_overvolt_protect,
  output logic overtemp_protect,
  output logic fault_active
);
  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // The comparators are slow next to the clock, so two flops per flag cost
  // nothing in reaction time and keep metastable levels out of the sequencer.
  logic feedback_s;
  logic ov_s;
  logic v12_s;
  logic v9_s;
  logic v6_s;
  logic tt_s;
  logic tr_s;

  fpar_sync u_feedback (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(feedback_level_high),
    .q(feedback_s)
  );

  fpar_sync u_ov (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(vdd_above_28v),
    .q(ov_s)
  );

  fpar_sync u_12 (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(vdd_above_12v),
    .q(v12_s)
  );

  fpar_sync u_9 (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(vdd_above_9v),
    .q(v9_s)
  );

  fpar_sync u_6 (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(vdd_above_6v),
    .q(v6_s)
  );

  fpar_sync u_tt (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(temp_above_trip),
    .q(tt_s)
  );

  fpar_sync u_tr (
    .clk(clk),
    .rst_n(rst_n),
    .d_async(temp_above_release),
    .q(tr_s)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // All state lives in one record so that reset and update stay in one place.
  typedef struct packed {
    fpar_pkg::fpar_state_t st;
    logic [fpar_pkg::OVLD_CW-1:0] ovld_cnt;
    logic [fpar_pkg::OVOLT_CW-1:0] ovolt_cnt;
    logic ovld;
    logic ovolt;
    logic otp;
    logic sw;
    logic lowi;
    logic recharge;
  } fpar_regs_t;

  fpar_regs_t s_reg;
  fpar_regs_t s_next;
  logic ovld_trip;
  logic ovolt_trip;
  logic otp_trip;
  logic any_trip;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // Overload timer counts only while feedback is continuously high.
    // It saturates at the trip point, so a long overload cannot wrap it.
    ovld_trip = 1'b0;
    if (!feedback_s) begin
      s_next.ovld_cnt = '0;
    end else if (s_reg.ovld_cnt > fpar_pkg::OVLD_LIMIT) begin
      ovld_trip = 1'b1;
    end else begin
      s_next.ovld_cnt = s_reg.ovld_cnt + 1'b1;
    end
    // Debounce keeps switching noise spikes from tripping the over-voltage path.
    ovolt_trip = 1'b0;
    if (!ov_s) begin
      s_next.ovolt_cnt = '0;
    end else if (s_reg.ovolt_cnt >= fpar_pkg::OVOLT_LIMIT) begin
      ovolt_trip = 1'b1;
    end else begin
      s_next.ovolt_cnt = s_reg.ovolt_cnt + 1'b1;
    end
    // Temperature needs no debounce: the die cannot change in a clock period.
    otp_trip = tt_s;
    // Trips only count while switching; in the other states they are moot.
    any_trip = (ovld_trip || ovolt_trip || otp_trip) && (s_reg.st == fpar_pkg::FPAR_ST_RUN);
    // Over-temperature flag holds until the release comparator drops.
    if (s_reg.otp && !tr_s && !tt_s) begin
      s_next.otp = 1'b0;
    end
    case (s_reg.st)
      fpar_pkg::FPAR_ST_CHARGE: begin
        s_next.sw = 1'b0;
        s_next.lowi = 1'b0;
        s_next.recharge = 1'b1;
        // A hot die blocks restart even when the supply is ready.
        if (v12_s && !s_reg.otp) begin
          s_next.st = fpar_pkg::FPAR_ST_RUN;
          s_next.sw = 1'b1;
          s_next.recharge = 1'b0;
        end
      end
      fpar_pkg::FPAR_ST_RUN: begin
        // A trip wins over a low supply so the slow discharge profile is used.
        if (any_trip) begin
          s_next.st = fpar_pkg::FPAR_ST_FAULT_FALL;
          s_next.sw = 1'b0;
          s_next.ovld = ovld_trip;
          s_next.ovolt = ovolt_trip;
          s_next.otp = s_reg.otp || otp_trip;
        end else if (!v6_s) begin
          s_next.st = fpar_pkg::FPAR_ST_CHARGE;
          s_next.sw = 1'b0;
          s_next.recharge = 1'b1;
        end
      end
      fpar_pkg::FPAR_ST_FAULT_FALL: begin
        s_next.sw = 1'b0;
        if (!v9_s) begin
          s_next.st = fpar_pkg::FPAR_ST_FAULT_SLOW;
          s_next.lowi = 1'b1;
        end
      end
      fpar_pkg::FPAR_ST_FAULT_SLOW: begin
        s_next.sw = 1'b0;
        // The temperature flag survives here; it gates the restart instead.
        if (!v6_s) begin
          s_next.st = fpar_pkg::FPAR_ST_CHARGE;
          s_next.lowi = 1'b0;
          s_next.recharge = 1'b1;
          s_next.ovld = 1'b0;
          s_next.ovolt = 1'b0;
        end
      end
      default: begin
        // Unused codes fall back to charging with the switch off.
        s_next.st = fpar_pkg::FPAR_ST_CHARGE;
        s_next.sw = 1'b0;
        s_next.lowi = 1'b0;
        s_next.recharge = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '{st: fpar_pkg::FPAR_ST_CHARGE, ovld_cnt: '0, ovolt_cnt: '0, ovld: 1'b0,
                 ovolt: 1'b0, otp: 1'b0, sw: 1'b0, lowi: 1'b0, recharge: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a plain copy of a register bit, so no glitch reaches a pin.
  always_comb begin
    switch_en = s_reg.sw;
    low_current_mode = s_reg.lowi;
    high_voltage_startup_en = s_reg.recharge;
    overload_protect = s_reg.ovld;
    supply_overvolt_protect = s_reg.ovolt;
    overtemp_protect = s_reg.otp;
    fault_active = s_reg.st[1];
  end
endmodule
`default_nettype wire

/* File: test/fpar_rail_model.sv */
// Purpose: Supply, feedback and die temperature comparators.
// Assumes: Quantities in whole volts and degrees.
// Notes: Flags follow the inputs at once.
`timescale 1ns/1ps
`default_nettype none
module fpar_rail_model (
  // Quantities
  input wire logic [7:0] vdd_v,
  input wire logic [7:0] temp_c,
  input wire logic feedback_high,
  // Flags
  output logic feedback_level_high,
  output logic vdd_above_28v,
  output logic vdd_above_12v,
  output logic vdd_above_9v,
  output logic vdd_above_6v,
  output logic temp_above_trip,
  output logic temp_above_release
);
  assign feedback_level_high = feedback_high;
  assign vdd_above_28v = vdd_v >= 8'h1C;
  assign vdd_above_12v = vdd_v >= 8'h0C;
  assign vdd_above_9v = vdd_v > 8'h09;
  assign vdd_above_6v = vdd_v > 8'h06;
  assign temp_above_trip = temp_c > 8'h8C;
  assign temp_above_release = temp_c > 8'h73;
endmodule
`default_nettype wire

/* File: test/fpar_top_chk.sv */
// Purpose: Port checks for the protection sequencer.
// Assumes: Bound to fpar_top.
// Notes: Run counters stand in for long windows.
`timescale 1ns/1ps
`default_nettype none
module fpar_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic feedback_level_high,
  input wire logic vdd_above_28v,
  input wire logic vdd_above_6v,
  input wire logic temp_above_release,
  input wire logic switch_en,
  input wire logic low_current_mode,
  input wire logic high_voltage_startup_en,
  input wire logic overload_protect,
  input wire logic supply_overvolt_protect,
  input wire logic overtemp_protect,
  input wire logic fault_active
);
  int unsigned feedback_run, ov_run;
  always_ff @(posedge clk) begin
    feedback_run <= feedback_level_high ? feedback_run + 1 : 0;
    ov_run <= vdd_above_28v ? ov_run + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_overload_window: assert property ($rose(overload_protect) |-> feedback_run >= 1120000)
    else $error("overload early");
  a_overvolt_debounce: assert property ($rose(supply_overvolt_protect) |-> ov_run >= 3000)
    else $error("overvolt early");
  a_trip_sw_off: assert property ((overload_protect || supply_overvolt_protect) |-> !switch_en)
    else $error("switching in fault");
  a_otp_hold: assert property ((overtemp_protect && temp_above_release) [*4] |=> overtemp_protect)
    else $error("early release");
  a_low_cur_fault: assert property (low_current_mode |-> fault_active && !switch_en)
    else $error("low current outside fault");
  a_run_no_hv: assert property (switch_en |-> !high_voltage_startup_en && !overtemp_protect)
    else $error("run with charge");
  a_six_stop: assert property (!vdd_above_6v [*5] |-> !switch_en)
    else $error("switching below 6 V");
  a_fault_exit: assert property ($fell(fault_active) |-> high_voltage_startup_en)
    else $error("no recharge");
endmodule
bind fpar_top fpar_top_chk fpar_top_chk_inst (.clk, .rst_n, .feedback_level_high, .vdd_above_28v,
  .vdd_above_6v, .temp_above_release, .switch_en, .low_current_mode, .high_voltage_startup_en,
  .overload_protect, .supply_overvolt_protect, .overtemp_protect, .fault_active);
`default_nettype wire

/* File: test/fpar_top_test.sv */
// Purpose: Self-checking bench for the protection sequencer.
// Assumes: 50 ns clock.
// Notes: The overload window is too long to run here.
`timescale 1ns/1ps
`default_nettype none
module fpar_top_test;
  logic clk = 1'b0, rst_n = 1'b0, feedback_in = 1'b0;
  logic [7:0] vdd = 8'h00, tmp = 8'h19;
  logic feedback_level_high, vdd_above_28v, vdd_above_12v, vdd_above_9v, vdd_above_6v;
  logic temp_above_trip, temp_above_release, switch_en, low_current_mode;
  logic high_voltage_startup_en, overload_protect, supply_overvolt_protect;
  logic overtemp_protect, fault_active;
  int miscompares = 0, cmp_count = 0;
  always #25 clk = ~clk;
  fpar_rail_model fpar_rail_model_inst (.vdd_v(vdd), .temp_c(tmp), .feedback_high(feedback_in),
    .feedback_level_high,
    .vdd_above_28v, .vdd_above_12v, .vdd_above_9v, .vdd_above_6v, .temp_above_trip,
    .temp_above_release);
  fpar_top fpar_top_inst (.clk, .rst_n, .feedback_level_high, .vdd_above_28v, .vdd_above_12v,
    .vdd_above_9v, .vdd_above_6v, .temp_above_trip, .temp_above_release, .switch_en,
    .low_current_mode, .high_voltage_startup_en, .overload_protect, .supply_overvolt_protect,
    .overtemp_protect, .fault_active);
  task check(string n, logic s, logic e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %b seen %b", n, e, s);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task set_in(logic [7:0] v, logic [7:0] t, int n);
    @(posedge clk);
    vdd <= v;
    tmp <= t;
    repeat (n) @(posedge clk);
    // Outputs are looked at mid-period, where they have settled.
    @(negedge clk);
  endtask
  task wait_sw(logic e);
    for (int i = 0; i < 20 && switch_en !== e; i++) @(negedge clk);
    check("switch_en", switch_en, e);
    if (switch_en !== e) stop_test;
  endtask
  task t_ovp;
    set_in(8'h0D, 8'h19, 0);
    wait_sw(1'b1);
    set_in(8'h1D, 8'h19, 2000);
    set_in(8'h0D, 8'h19, 8);
    check("overvolt", supply_overvolt_protect, 1'b0);
    set_in(8'h1D, 8'h19, 3010);
    check("overvolt", supply_overvolt_protect, 1'b1);
    check("switch_en", switch_en, 1'b0);
    set_in(8'h0A, 8'h19, 8);
    check("fault", fault_active, 1'b1);
    check("lcm", low_current_mode, 1'b0);
    set_in(8'h08, 8'h19, 8);
    check("lcm", low_current_mode, 1'b1);
    set_in(8'h05, 8'h19, 8);
    check("overvolt", supply_overvolt_protect, 1'b0);
    check("startup", high_voltage_startup_en, 1'b1);
    check("switch_en", switch_en, 1'b0);
  endtask
  task t_brown;
    set_in(8'h0D, 8'h19, 0);
    wait_sw(1'b1);
    @(posedge clk);
    feedback_in <= 1'b1;
    set_in(8'h0D, 8'h19, 5000);
    check("overload", overload_protect, 1'b0);
    check("switch_en", switch_en, 1'b1);
    @(posedge clk);
    feedback_in <= 1'b0;
    set_in(8'h05, 8'h19, 8);
    check("switch_en", switch_en, 1'b0);
    check("startup", high_voltage_startup_en, 1'b1);
    check("fault", fault_active, 1'b0);
    check("lcm", low_current_mode, 1'b0);
  endtask
  task t_otp;
    set_in(8'h0D, 8'h19, 0);
    wait_sw(1'b1);
    set_in(8'h0D, 8'h91, 8);
    check("otp", overtemp_protect, 1'b1);
    set_in(8'h05, 8'h82, 8);
    set_in(8'h0D, 8'h82, 20);
    check("switch_en", switch_en, 1'b0);
    set_in(8'h0D, 8'h64, 0);
    wait_sw(1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_ovp;
    t_otp;
    t_brown;
    stop_test;
  end
endmodule
`default_nettype wire
